// [design/ibb_pkg.sv]
// constants for the indicator blink/breathe controller
package ibb_pkg;
  localparam logic [15:0] IBB_ADDR_CTL1 = 16'h0806;
  localparam logic [15:0] IBB_ADDR_CTL2 = 16'h0807;
  localparam logic [7:0]  IBB_CTL_RESET = 8'h00;
  localparam int IBB_BIT_INVERT   = 7;
  localparam int IBB_BIT_MODE     = 6;
  localparam int IBB_RATE_HI      = 5;
  localparam int IBB_RATE_LO      = 0;
  localparam int IBB_TRAIL_HI     = 7;
  localparam int IBB_TRAIL_LO     = 2;
  localparam int IBB_BIT_ACTIVATE = 1;
  localparam int IBB_BIT_PINSEL   = 0;
  localparam int IBB_FIELD_W      = 6;
  localparam int IBB_CLK_MHZ      = 200;
  localparam int IBB_TICK_US      = 1000;
  localparam int IBB_TICK_CYCLES  = IBB_CLK_MHZ * IBB_TICK_US;
  localparam int IBB_BLINK_STEP_MS   = 50;
  localparam int IBB_BREATHE_STEP_MS = 500;
  localparam int IBB_PWM_W        = 8;
  localparam logic [15:0] IBB_MS_ONE = 16'h0001;
  typedef enum logic [1:0]
  {
    IBB_IDLE  = 2'b00,
    IBB_BLINK = 2'b01,
    IBB_BREATH = 2'b10,
    IBB_SLEEP = 2'b11
  } ibb_state_t;
endpackage

// [design/ibb_tick.sv]
// prescaler producing one-cycle millisecond ticks
`timescale 1ns/1ps
module ibb_tick #(
  parameter int TICK_CYCLES = ibb_pkg::IBB_TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // tick out
  output logic      tick_o
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;

  always_comb
  begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 32'h1;
    if (cnt_ff == 32'(TICK_CYCLES - 1))
    begin
      nxt_cnt  = 32'h0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule

// [design/ibb_ctrl.sv]
// indicator blink/breathe controller with its two control registers
// Summary of operation
// - control-one bit 7 set inverts the level driven on the indicator output.
// - control-one bit 6 picks blink (0) or breathe (1); blink period is bits 5:0, 50 ms steps.
// - blink drives a 50% duty cycle, period from one 50 ms step up to 3.15 s.
// - in breathe bits 5:0 give the length of one breath in 500 ms steps.
// - in blink bits 7:2 of control two are the trail after deactivation, in 50 ms steps.
// - in breathe control-two bits 7:2 give the idle time between breaths, in 500 ms steps.
// - control-two bit 1 set starts blinking or breathing per the mode.
// - the timer starts when activate is set and a started blink cycle always runs to full length.
// - in blink, after activate clears, blinking goes on for the trail interval and then stops.
// - in breathe, clearing activate stops the output at once.
// - control-two bit 0 chooses general pin (0) or indicator output (1).
`timescale 1ns/1ps
module ibb_ctrl #(
  parameter int TICK_CYCLES = ibb_pkg::IBB_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // general-purpose path for the shared pin
  input  wire logic        gp_out_i,
  input  wire logic        gp_oe_n_i,
  // shared pin
  input  wire logic        indicator_general_pin_zero_i,
  output logic             indicator_general_pin_zero_o,
  output logic             indicator_general_pin_zero_oe_n_o,
  output logic             gp_in_o,
  output logic             indicator_busy_o
);
  localparam int FW = ibb_pkg::IBB_FIELD_W;
  localparam int PW = ibb_pkg::IBB_PWM_W;

  logic [7:0]  ctl1_ff;
  logic [7:0]  ctl2_ff;
  logic [7:0]  nxt_ctl1;
  logic [7:0]  nxt_ctl2;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;

  ibb_pkg::ibb_state_t state_ff;
  ibb_pkg::ibb_state_t nxt_state;
  logic [15:0] ms_ff;
  logic [15:0] nxt_ms;
  logic [15:0] trail_ff;
  logic [15:0] nxt_trail;
  logic        trailing_ff;
  logic        nxt_trailing;
  logic        act_d_ff;
  logic        lamp_ff;
  logic        nxt_lamp;
  logic [PW-1:0] pwm_ff;
  logic [PW-1:0] nxt_pwm;
  logic [PW-1:0] duty;
  logic        pin_ff;
  logic        nxt_pin;
  logic        oe_n_ff;
  logic        nxt_oe_n;
  logic        gpin_ff;
  logic        busy_ff;
  logic        nxt_busy;
  logic        tick;

  logic        invert;
  logic        breathe;
  logic        activate;
  logic        pin_sel;
  logic [FW-1:0] rate;
  logic [FW-1:0] trail;
  logic        act_rise;
  logic [15:0] period_ms;
  logic [15:0] half_ms;
  logic [15:0] sleep_ms;
  logic [15:0] blink_trail_ms;

  // field value times step, in ms
  function automatic logic [15:0] steps_ms(input logic [FW-1:0] n, input int step);
    steps_ms = 16'(int'(n) * step);
  endfunction

  ibb_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  assign invert   = ctl1_ff[ibb_pkg::IBB_BIT_INVERT];
  assign breathe  = ctl1_ff[ibb_pkg::IBB_BIT_MODE];
  assign rate     = ctl1_ff[ibb_pkg::IBB_RATE_HI:ibb_pkg::IBB_RATE_LO];
  assign trail    = ctl2_ff[ibb_pkg::IBB_TRAIL_HI:ibb_pkg::IBB_TRAIL_LO];
  assign activate = ctl2_ff[ibb_pkg::IBB_BIT_ACTIVATE];
  assign pin_sel  = ctl2_ff[ibb_pkg::IBB_BIT_PINSEL];
  assign act_rise = activate & ~act_d_ff;

  // zero field still gives one step so a cycle never collapses
  always_comb
  begin
    period_ms      = steps_ms((rate == '0) ? FW'(1) : rate,
                              ibb_pkg::IBB_BLINK_STEP_MS);
    half_ms        = period_ms >> 1;
    if (breathe)
    begin
      period_ms    = steps_ms((rate == '0) ? FW'(1) : rate,
                              ibb_pkg::IBB_BREATHE_STEP_MS);
      half_ms      = period_ms >> 1;
    end
    sleep_ms       = steps_ms(trail, ibb_pkg::IBB_BREATHE_STEP_MS);
    blink_trail_ms = steps_ms(trail, ibb_pkg::IBB_BLINK_STEP_MS);
  end

  // register port: single-byte accesses at the two control addresses
  always_comb
  begin
    nxt_ctl1   = ctl1_ff;
    nxt_ctl2   = ctl2_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = reg_rd_i;
    if (reg_wr_i && reg_addr_i == ibb_pkg::IBB_ADDR_CTL1)
    begin
      nxt_ctl1 = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == ibb_pkg::IBB_ADDR_CTL2)
    begin
      nxt_ctl2 = reg_wdata_i;
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ibb_pkg::IBB_ADDR_CTL1: nxt_rdata = ctl1_ff;
        ibb_pkg::IBB_ADDR_CTL2: nxt_rdata = ctl2_ff;
        default:                nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl1_ff   <= ibb_pkg::IBB_CTL_RESET;
      ctl2_ff   <= ibb_pkg::IBB_CTL_RESET;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      ctl1_ff   <= nxt_ctl1;
      ctl2_ff   <= nxt_ctl2;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // sequencer: ms counter runs within a phase, blink periods end only at full length, breathe phases end when activate clears
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_ms       = ms_ff;
    nxt_trail    = trail_ff;
    nxt_trailing = trailing_ff;
    nxt_lamp     = lamp_ff;
    if (tick)
    begin
      nxt_ms = ms_ff + ibb_pkg::IBB_MS_ONE;
    end
    unique case (state_ff)
      ibb_pkg::IBB_IDLE:
      begin
        nxt_lamp     = 1'b0;
        nxt_trailing = 1'b0;
        if (act_rise)
        begin
          nxt_ms    = 16'h0000;
          nxt_lamp  = 1'b1;
          nxt_state = breathe ? ibb_pkg::IBB_BREATH : ibb_pkg::IBB_BLINK;
        end
      end
      ibb_pkg::IBB_BLINK:
      begin
        if (!activate && !trailing_ff)
        begin
          nxt_trailing = 1'b1;
          nxt_trail    = 16'h0000;
        end
        else if (trailing_ff && tick)
        begin
          nxt_trail = trail_ff + ibb_pkg::IBB_MS_ONE;
        end
        if (activate)
        begin
          nxt_trailing = 1'b0; // re-arm cancels a pending trail
        end
        if (tick && nxt_ms >= half_ms && lamp_ff)
        begin
          nxt_lamp = 1'b0;
        end
        if (tick && nxt_ms >= period_ms)
        begin
          nxt_ms   = 16'h0000;
          nxt_lamp = 1'b1;
          if (trailing_ff && nxt_trail >= blink_trail_ms)
          begin
            nxt_lamp  = 1'b0;
            nxt_state = ibb_pkg::IBB_IDLE;
          end
        end
      end
      ibb_pkg::IBB_BREATH:
      begin
        if (tick && nxt_ms >= period_ms)
        begin
          nxt_ms    = 16'h0000;
          nxt_state = ibb_pkg::IBB_SLEEP;
        end
      end
      ibb_pkg::IBB_SLEEP:
      begin
        if (tick && nxt_ms >= sleep_ms)
        begin
          nxt_ms    = 16'h0000;
          nxt_state = ibb_pkg::IBB_BREATH;
        end
      end
    endcase
    if (!activate && (state_ff == ibb_pkg::IBB_BREATH || state_ff == ibb_pkg::IBB_SLEEP))
    begin
      nxt_state = ibb_pkg::IBB_IDLE;
      nxt_ms    = 16'h0000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff    <= ibb_pkg::IBB_IDLE;
      ms_ff       <= 16'h0000;
      trail_ff    <= 16'h0000;
      trailing_ff <= 1'b0;
      act_d_ff    <= 1'b0;
      lamp_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      ms_ff       <= nxt_ms;
      trail_ff    <= nxt_trail;
      trailing_ff <= nxt_trailing;
      act_d_ff    <= activate;
      lamp_ff     <= nxt_lamp;
    end
  end

  // triangle brightness over one breath; coarse, with two divides by half plus one
  always_comb
  begin
    duty = '0;
    if (half_ms != 16'h0000)
    begin
      if (ms_ff < half_ms)
      begin
        // divide by half plus one so the peak never wraps to dark
        duty = PW'((32'(ms_ff) << PW) / 32'(half_ms + 16'h0001));
      end
      else if (ms_ff < period_ms)
      begin
        duty = PW'((32'(period_ms - ms_ff) << PW) / 32'(half_ms + 16'h0001));
      end
    end
    nxt_pwm = pwm_ff + PW'(1);
  end

  // pin mux and output stage
  always_comb
  begin
    logic level;
    level = 1'b0;
    unique case (state_ff)
      ibb_pkg::IBB_BLINK:  level = lamp_ff;
      ibb_pkg::IBB_BREATH: level = (pwm_ff < duty);
      default:             level = 1'b0;
    endcase
    nxt_busy = (state_ff != ibb_pkg::IBB_IDLE);
    if (pin_sel)
    begin
      nxt_pin  = level ^ invert;
      nxt_oe_n = 1'b0;
    end
    else
    begin
      nxt_pin  = gp_out_i;
      nxt_oe_n = gp_oe_n_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_ff  <= '0;
      pin_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
      gpin_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      pwm_ff  <= nxt_pwm;
      pin_ff  <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
      gpin_ff <= indicator_general_pin_zero_i;
      busy_ff <= nxt_busy;
    end
  end

  assign reg_rdata_o                       = rdata_ff;
  assign reg_rvalid_o                      = rvalid_ff;
  assign indicator_general_pin_zero_o      = pin_ff;
  assign indicator_general_pin_zero_oe_n_o = oe_n_ff;
  assign gp_in_o                           = gpin_ff;
  assign indicator_busy_o                  = busy_ff;
endmodule

// [verification/ibb_lamp.sv]
// indicator lamp load on the shared pin
`timescale 1ns/1ps
module ibb_lamp (
  // pin drive from the device
  input  wire logic drive_i,
  input  wire logic oe_n_i,
  // resolved pin level
  output logic      pin_o
);
  // weak pull-down: a released pin reads low
  assign pin_o = oe_n_i ? 1'b0 : drive_i;
endmodule

// [verification/ibb_ctrl_asserts.sv]
// assertion checker for the indicator controller
`timescale 1ns/1ps
module ibb_ctrl_asserts #(
  parameter int TICK_CYCLES = 2
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_rvalid_o,
  // pin side
  input wire logic        gp_out_i,
  input wire logic        gp_oe_n_i,
  input wire logic        indicator_general_pin_zero_i,
  input wire logic        indicator_general_pin_zero_o,
  input wire logic        indicator_general_pin_zero_oe_n_o,
  input wire logic        gp_in_o,
  input wire logic        indicator_busy_o
);
  logic [7:0]  c1_ff, c2_ff, nxt_c1, nxt_c2;
  logic [15:0] seg_ff, nxt_seg, half;
  logic        pin_ff, run_ff, nxt_run, chg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow registers, so no internal probes are needed
  always_comb
  begin
    nxt_c1 = (reg_wr_i && reg_addr_i == ibb_pkg::IBB_ADDR_CTL1) ? reg_wdata_i : c1_ff;
    nxt_c2 = (reg_wr_i && reg_addr_i == ibb_pkg::IBB_ADDR_CTL2) ? reg_wdata_i : c2_ff;
    chg = indicator_general_pin_zero_o != pin_ff;
    nxt_seg = chg ? 16'h0001 : seg_ff + 16'h0001;
    // first edge only arms the check, its segment began in idle
    nxt_run = indicator_busy_o && !c1_ff[6] && (run_ff || chg);
    half = 16'((c1_ff[5:0] == 6'h00 ? 1 : int'(c1_ff[5:0])) * 25 * TICK_CYCLES);
  end
  always_ff @(posedge clk_i)
  begin
    c1_ff <= rst_i ? 8'h00 : nxt_c1;
    c2_ff <= rst_i ? 8'h00 : nxt_c2;
    seg_ff <= rst_i ? 16'h0000 : nxt_seg;
    run_ff <= rst_i ? 1'b0 : nxt_run;
    pin_ff <= indicator_general_pin_zero_o;
  end
  rd_valid_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  ctl_readback_a: assert property (reg_rd_i && reg_addr_i == ibb_pkg::IBB_ADDR_CTL1 |=>
    reg_rdata_o == $past(c1_ff)) else $error("control one readback wrong");
  gp_follow_a: assert property (!$past(c2_ff[0]) |->
    indicator_general_pin_zero_o == $past(gp_out_i) &&
    indicator_general_pin_zero_oe_n_o == $past(gp_oe_n_i)) else $error("general pin wrong");
  drive_enable_a: assert property ($past(c2_ff[0]) |->
    !indicator_general_pin_zero_oe_n_o) else $error("indicator pin not driven");
  start_busy_a: assert property (c2_ff[1] && !$past(c2_ff[1]) && !indicator_busy_o |->
    ##[1:3] indicator_busy_o) else $error("activate did not start");
  breathe_stop_a: assert property (c1_ff[6] && $fell(c2_ff[1]) |->
    ##[1:3] !indicator_busy_o) else $error("breathe did not stop");
  blink_half_a: assert property (chg && run_ff |->
    seg_ff + TICK_CYCLES + 2 >= half && seg_ff <= half + TICK_CYCLES + 2)
    else $error("blink half period wrong");
  idle_level_a: assert property (
    (!indicator_busy_o && !c2_ff[1] && c2_ff[0] && !reg_wr_i)[*3]
    |-> indicator_general_pin_zero_o == c1_ff[7]) else $error("idle level wrong");
  cover property (chg && run_ff);
  cover property (c1_ff[6] && indicator_busy_o && chg);
  cover property (c1_ff[6] && $fell(c2_ff[1]));
  cover property (!c1_ff[6] && $fell(c2_ff[1]) && c2_ff[7:2] != 6'h00);
endmodule
bind ibb_ctrl ibb_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// [verification/ibb_ctrl_tb.sv]
// random and directed bench for the indicator controller
`timescale 1ns/1ps
module ibb_ctrl_tb;
  localparam int          TK = 2;
  localparam logic [15:0] A1 = ibb_pkg::IBB_ADDR_CTL1;
  localparam logic [15:0] A2 = ibb_pkg::IBB_ADDR_CTL2;
  logic        clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        gp_out_i = 1'b0, gp_oe_n_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0000, ua;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, c1;
  logic        reg_rvalid_o, pin_i, pin_o, oe_n, gp_in_o, indicator_busy_o;
  int          errors = 0, check_count = 0, h, r, p;
  always #2.5 clk_i = ~clk_i;
  ibb_ctrl #(.TICK_CYCLES(TK)) uut (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .gp_out_i, .gp_oe_n_i,
    .indicator_general_pin_zero_i(pin_i), .indicator_general_pin_zero_o(pin_o),
    .indicator_general_pin_zero_oe_n_o(oe_n), .gp_in_o, .indicator_busy_o);
  ibb_lamp lamp (.drive_i(pin_o), .oe_n_i(oe_n), .pin_o(pin_i));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  function automatic logic lvl(input logic [7:0] c, input logic on);
    return on ^ c[7];
  endfunction
  // all bus tasks start and end on a falling edge
  task automatic wreg(input logic [15:0] a, input logic [7:0] v);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chb("rvalid", 1'b1, reg_rvalid_o);
    chk("rdata", e, reg_rdata_o);
    @(negedge clk_i);
  endtask
  // counts cycles with the pin away from its idle level
  task automatic watch(input int n, input logic idle, output int seen);
    seen = 0;
    repeat (n)
    begin
      @(negedge clk_i);
      if (pin_o !== idle)
        seen++;
    end
  endtask
  task automatic summarize;
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #50000;
    errors++;
    summarize;
  end
  initial
  begin
    void'($urandom(15));
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    rreg(A1, ibb_pkg::IBB_CTL_RESET);
    rreg(A2, ibb_pkg::IBB_CTL_RESET);
    repeat (8)
    begin
      c1 = 8'($urandom);
      p = $urandom;
      ua = {p[15:4], 4'h8};
      wreg(A1, c1);
      wreg(ua, ~c1);
      rreg(A1, c1);
      rreg(ua, 8'h00);
      gp_out_i = p[0];
      gp_oe_n_i = p[1];
      repeat (2) @(negedge clk_i);
      chb("pin", p[0], pin_o);
      chb("oe_n", p[1], oe_n);
      chb("gp_in", p[0] & ~p[1], gp_in_o);
    end
    // blink, trail zero then trail of two periods
    for (int i = 0; i < 2; i++)
    begin
      r = 1 + $urandom % 3;
      h = r * 25 * TK;
      c1 = {i[0], 1'b0, 6'(r)};
      wreg(A1, c1);
      wreg(A2, 8'h03);
      repeat (h / 2) @(negedge clk_i);
      chb("blink_on", lvl(c1, 1'b1), pin_o);
      repeat (h) @(negedge clk_i);
      chb("blink_off", lvl(c1, 1'b0), pin_o);
      wreg(A2, {6'(2 * r * i), 2'b01});
      rreg(A2, {6'(2 * r * i), 2'b01});
      repeat (h / 2 + 4 * h * i - 10) @(negedge clk_i);
      chb("trail_busy", 1'b1, indicator_busy_o);
      repeat (20) @(negedge clk_i);
      chb("trail_done", 1'b0, indicator_busy_o);
      chb("blink_idle", lvl(c1, 1'b0), pin_o);
    end
    c1 = {1'($urandom), 7'h41};
    wreg(A1, c1);
    wreg(A2, 8'h07);
    repeat (50) @(negedge clk_i);
    chb("breathe_busy", 1'b1, indicator_busy_o);
    // early in a breath the duty is partial, so both levels show
    watch(256, lvl(c1, 1'b0), h);
    chb("breathe_pwm", 1'b1, h > 0 && h < 256);
    // one breath is 1000 cycles here, the sleep after it another 1000
    repeat (1100) @(negedge clk_i);
    watch(200, lvl(c1, 1'b0), h);
    chb("sleep_dark", 1'b1, h == 0);
    chb("sleep_busy", 1'b1, indicator_busy_o);
    wreg(A2, 8'h05);
    repeat (2) @(negedge clk_i);
    chb("breathe_stop", 1'b0, indicator_busy_o);
    chb("breathe_idle", lvl(c1, 1'b0), pin_o);
    summarize;
  end
endmodule
